/* File: inc/srtc_params.svh */
// Constants of the sync rotation and transmit mute control block.
// Assumes inclusion by its bare name from the design file.
// Functional notes
// - NCO reset bit, default 1, resets all NCOs after digital reset or rotation.
// - That bit or the sync kick bit resets main and channel NCOs.
// - Two-bit realign action field, reset zero; zero means no link or datapath action.
// - Action bit 0: rotation drops links, resets and realigns serial-link clocks.
// - Action bit 1: datapath ramps off and back on around the rotation.
// - Action value 11 performs both clock reset and datapath soft off/on.
// - DAC1 mute enable bit 5: pin 1 low zeroes DAC1 output at once.
// - DAC0 mute enable bit 4 gates pin 0 muting; cleared means normal output.
// - Cleared mute enable passes output normally; both enables reset to zero.
// - One-shot mode rotates once on next reference edge, then returns to monitor.
`ifndef SRTC_PARAMS_SVH
`define SRTC_PARAMS_SVH
`define SRTC_TX_MUTE_ADDR      8'h3f
`define SRTC_REALIGN_ADDR      8'h3b
`define SRTC_NCO_SYNC_ADDR     8'he7
`define SRTC_MUTE1_BIT         5
`define SRTC_MUTE0_BIT         4
`define SRTC_NCORST_BIT        4
`define SRTC_ONESHOT_BIT       3
`define SRTC_DONE_BIT          2
`define SRTC_KICK_BIT          0
`define SRTC_NCORST_RST        1'b1
`define SRTC_ACTION_RST        2'h0
`define SRTC_MUTE_RST          1'b0
`define SRTC_RAMP_CYCLES       16
`define SRTC_LINK_RST_CYCLES   4
`endif

/* File: inc/srtc_pkg.sv */
// Types of the sync rotation and transmit mute control block.
// Assumes nothing beyond the compile order.
package srtc_pkg;
	typedef enum logic [2:0] {
		SRTC_IDLE,
		SRTC_RAMP_DOWN,
		SRTC_ROTATE,
		SRTC_RAMP_UP
	} srtc_state_t;
endpackage

/* File: rtl/srtc_ctrl.sv */
// Sync rotation action control and transmit-enable pin muting.
// Assumes register port and pins synchronous to ref_clk; rotation occurs on a reference edge.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "srtc_params.svh"
module srtc_ctrl #(
	parameter int RAMP_CYCLES = `SRTC_RAMP_CYCLES,
	parameter int GAIN_W      = 8
) (
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic              clk_en,
	input  wire logic [8:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	input  wire logic              sysref_edge,
	input  wire logic              digital_reset,
	input  wire logic              tx_enable_pin_0,
	input  wire logic              tx_enable_pin_1,
	output logic                   nco_reset,
	output logic                   link_clk_reset,
	output logic                   rotate_pulse,
	output logic [GAIN_W-1:0]      datapath_gain,
	output logic                   dac0_mute,
	output logic                   dac1_mute
);
	localparam logic [GAIN_W-1:0] GAIN_FULL = {GAIN_W{1'b1}};
	localparam int CW = $clog2(RAMP_CYCLES + 1);

	logic                      nco_reset_on_realign_en_reg, nco_reset_on_realign_en_next;
	logic [1:0]                action_reg, action_next;
	logic                      single_shot_realign_en_reg, single_shot_realign_en_next;
	logic                      dac0_pin_mute_en_reg, dac0_pin_mute_en_next;
	logic                      dac1_pin_mute_en_reg, dac1_pin_mute_en_next;
	logic                      nco_sync_kick_reg, nco_sync_kick_next;
	logic                      done_reg, done_next;
	logic [7:0]                rdata_reg, rdata_next;
	srtc_pkg::srtc_state_t     state_reg, state_next;
	logic [CW-1:0]             cnt_reg, cnt_next;
	logic [GAIN_W-1:0]         gain_reg, gain_next;
	logic                      nco_rst_reg, nco_rst_next;
	logic                      link_rst_reg, link_rst_next;
	logic                      rot_reg, rot_next;
	logic                      mute0_reg, mute0_next;
	logic                      mute1_reg, mute1_next;
	logic                      rotate_now;

	// Rotation happens on a reference edge while one-shot is armed and the sequencer is idle
	assign rotate_now = sysref_edge && single_shot_realign_en_reg && state_reg == srtc_pkg::SRTC_IDLE;

	always_comb begin
		nco_reset_on_realign_en_next = nco_reset_on_realign_en_reg;
		action_next                  = action_reg;
		single_shot_realign_en_next  = single_shot_realign_en_reg;
		dac0_pin_mute_en_next        = dac0_pin_mute_en_reg;
		dac1_pin_mute_en_next        = dac1_pin_mute_en_reg;
		nco_sync_kick_next           = 1'b0;
		done_next                    = done_reg;
		rdata_next                   = 8'h00;
		if (reg_wr) begin
			case (reg_addr)
				{1'b0, `SRTC_REALIGN_ADDR}: begin
					nco_reset_on_realign_en_next = reg_wdata[`SRTC_NCORST_BIT];
					single_shot_realign_en_next  = reg_wdata[`SRTC_ONESHOT_BIT];
					action_next                  = reg_wdata[1:0];
				end
				{1'b0, `SRTC_TX_MUTE_ADDR}: begin
					dac1_pin_mute_en_next = reg_wdata[`SRTC_MUTE1_BIT];
					dac0_pin_mute_en_next = reg_wdata[`SRTC_MUTE0_BIT];
				end
				{1'b1, `SRTC_NCO_SYNC_ADDR}: begin
					nco_sync_kick_next = reg_wdata[`SRTC_KICK_BIT];
				end
				default: begin
				end
			endcase
		end
		// One-shot disarms into monitor mode when its rotation starts; clear wins
		if (rotate_now) begin
			single_shot_realign_en_next = 1'b0;
			done_next                   = 1'b0;
		end else if (state_reg != srtc_pkg::SRTC_IDLE && state_next == srtc_pkg::SRTC_IDLE) begin
			done_next = 1'b1;
		end
		if (reg_rd) begin
			case (reg_addr)
				{1'b0, `SRTC_REALIGN_ADDR}: begin
					rdata_next = {3'h0, nco_reset_on_realign_en_reg, single_shot_realign_en_reg,
						done_reg, action_reg};
				end
				{1'b0, `SRTC_TX_MUTE_ADDR}: begin
					rdata_next = {2'h0, dac1_pin_mute_en_reg, dac0_pin_mute_en_reg, 4'h0};
				end
				default: begin
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	always_comb begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		gain_next     = gain_reg;
		rot_next      = 1'b0;
		link_rst_next = 1'b0;
		nco_rst_next  = digital_reset && nco_reset_on_realign_en_reg;
		if (nco_sync_kick_reg) begin
			nco_rst_next = 1'b1;
		end
		case (state_reg)
			srtc_pkg::SRTC_IDLE: begin
				gain_next = GAIN_FULL;
				if (rotate_now) begin
					if (action_reg[1]) begin
						state_next = srtc_pkg::SRTC_RAMP_DOWN;
						cnt_next   = CW'(RAMP_CYCLES);
					end else begin
						state_next = srtc_pkg::SRTC_ROTATE;
					end
				end
			end
			srtc_pkg::SRTC_RAMP_DOWN: begin
				// Linear ramp to zero
				gain_next = GAIN_W'((32'(GAIN_FULL) * (32'(cnt_reg) - 1)) / RAMP_CYCLES);
				cnt_next  = cnt_reg - 1'b1;
				if (cnt_reg == CW'(1)) begin
					state_next = srtc_pkg::SRTC_ROTATE;
				end
			end
			srtc_pkg::SRTC_ROTATE: begin
				rot_next      = 1'b1;
				link_rst_next = action_reg[0];
				nco_rst_next  = nco_reset_on_realign_en_reg || nco_sync_kick_reg;
				if (action_reg[1]) begin
					state_next = srtc_pkg::SRTC_RAMP_UP;
					cnt_next   = CW'(RAMP_CYCLES);
				end else begin
					state_next = srtc_pkg::SRTC_IDLE;
				end
			end
			srtc_pkg::SRTC_RAMP_UP: begin
				gain_next = GAIN_W'((32'(GAIN_FULL) * (RAMP_CYCLES - 32'(cnt_reg) + 1)) / RAMP_CYCLES);
				cnt_next  = cnt_reg - 1'b1;
				if (cnt_reg == CW'(1)) begin
					state_next = srtc_pkg::SRTC_IDLE;
				end
			end
			default: begin
				state_next = srtc_pkg::SRTC_IDLE;
			end
		endcase
		// Immediate pin mute, per DAC
		mute0_next = dac0_pin_mute_en_reg && !tx_enable_pin_0;
		mute1_next = dac1_pin_mute_en_reg && !tx_enable_pin_1;
	end

	// Register bank
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			nco_reset_on_realign_en_reg <= `SRTC_NCORST_RST;
			action_reg                  <= `SRTC_ACTION_RST;
			single_shot_realign_en_reg  <= 1'b0;
			dac0_pin_mute_en_reg        <= `SRTC_MUTE_RST;
			dac1_pin_mute_en_reg        <= `SRTC_MUTE_RST;
			nco_sync_kick_reg           <= 1'b0;
			done_reg                    <= 1'b1;
			rdata_reg                   <= 8'h00;
		end else if (clk_en) begin
			nco_reset_on_realign_en_reg <= nco_reset_on_realign_en_next;
			action_reg                  <= action_next;
			single_shot_realign_en_reg  <= single_shot_realign_en_next;
			dac0_pin_mute_en_reg        <= dac0_pin_mute_en_next;
			dac1_pin_mute_en_reg        <= dac1_pin_mute_en_next;
			nco_sync_kick_reg           <= nco_sync_kick_next;
			done_reg                    <= done_next;
			rdata_reg                   <= rdata_next;
		end
	end

	// Rotation sequencer and pin mute
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_reg                   <= srtc_pkg::SRTC_IDLE;
			cnt_reg                     <= '0;
			gain_reg                    <= GAIN_FULL;
			nco_rst_reg                 <= 1'b0;
			link_rst_reg                <= 1'b0;
			rot_reg                     <= 1'b0;
			mute0_reg                   <= 1'b0;
			mute1_reg                   <= 1'b0;
		end else if (clk_en) begin
			state_reg                   <= state_next;
			cnt_reg                     <= cnt_next;
			gain_reg                    <= gain_next;
			nco_rst_reg                 <= nco_rst_next;
			link_rst_reg                <= link_rst_next;
			rot_reg                     <= rot_next;
			mute0_reg                   <= mute0_next;
			mute1_reg                   <= mute1_next;
		end
	end

	assign reg_rdata      = rdata_reg;
	assign nco_reset      = nco_rst_reg;
	assign link_clk_reset = link_rst_reg;
	assign rotate_pulse   = rot_reg;
	assign datapath_gain  = gain_reg;
	assign dac0_mute      = mute0_reg;
	assign dac1_mute      = mute1_reg;

	sequence rot_seq;
		rot_reg;
	endsequence

	sequence ramp_start_seq;
		clk_en && rotate_now && action_reg[1];
	endsequence
	sequence plain_start_seq;
		clk_en && rotate_now && !action_reg[1];
	endsequence
	sequence ramp_down_seq;
		clk_en && state_reg == srtc_pkg::SRTC_RAMP_DOWN;
	endsequence
	sequence ramp_up_seq;
		clk_en && state_reg == srtc_pkg::SRTC_RAMP_UP;
	endsequence

	nco_on_rotate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && state_reg == srtc_pkg::SRTC_ROTATE && nco_reset_on_realign_en_reg) |=> nco_rst_reg)
		else $error("NCO reset missing on rotation");
	nco_kick_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && nco_sync_kick_reg) |=> nco_rst_reg)
		else $error("NCO reset missing on kick");
	no_action_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(action_reg == 2'h0) |-> (!link_rst_reg && gain_reg == GAIN_FULL))
		else $error("Action taken with field zero");
	link_reset_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		rot_seq |-> (link_rst_reg == $past(action_reg[0])))
		else $error("Link clock reset wrong");
	ramp_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(rot_seq and $past(action_reg[1])) |-> gain_reg == '0)
		else $error("Gain not zero at rotation");
	ramp_len_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && state_reg == srtc_pkg::SRTC_RAMP_UP && cnt_reg == CW'(1)) |=> gain_reg == GAIN_FULL)
		else $error("Gain not unity after ramp");
	both_actions_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(rot_seq and $past(action_reg) == 2'h3) |-> (link_rst_reg && gain_reg == '0))
		else $error("Both actions not performed");
	mute1_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && dac1_pin_mute_en_reg && !tx_enable_pin_1) |=> mute1_reg)
		else $error("DAC1 not muted");
	mute0_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && !dac0_pin_mute_en_reg) |=> !mute0_reg)
		else $error("DAC0 muted while disabled");
	mute_pass_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && !dac1_pin_mute_en_reg) |=> !mute1_reg)
		else $error("DAC1 muted while disabled");
	oneshot_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && rotate_now) |=> !single_shot_realign_en_reg)
		else $error("One-shot not disarmed");

	// Rotation sequencing steps
	ramp_enter_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ramp_start_seq |=> (state_reg == srtc_pkg::SRTC_RAMP_DOWN && gain_reg == GAIN_FULL))
		else $error("Ramp not entered at full gain");
	direct_rotate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		plain_start_seq |=> (state_reg == srtc_pkg::SRTC_ROTATE && gain_reg == GAIN_FULL))
		else $error("Gain touched without soft action");
	gain_fall_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ramp_down_seq |=> gain_reg <= $past(gain_reg))
		else $error("Gain rose during ramp down");
	gain_rise_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ramp_up_seq |=> gain_reg >= $past(gain_reg))
		else $error("Gain fell during ramp up");
	rot_once_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && rot_reg) |=> !rot_reg)
		else $error("Rotation pulse too long");
	done_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && rotate_now) |=> !done_reg)
		else $error("Done flag not cleared");
	done_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && state_reg == srtc_pkg::SRTC_ROTATE && !action_reg[1]) |=> done_reg)
		else $error("Done flag not set");
	edge_refused_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && sysref_edge && !single_shot_realign_en_reg && state_reg == srtc_pkg::SRTC_IDLE)
		|=> state_reg == srtc_pkg::SRTC_IDLE)
		else $error("Unarmed edge started a rotation");
	link_with_rot_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		link_rst_reg |-> rot_reg)
		else $error("Link reset outside rotation");
	dreset_nco_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && digital_reset && nco_reset_on_realign_en_reg) |=> nco_rst_reg)
		else $error("NCO reset missing after digital reset");
	kick_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && nco_sync_kick_reg && !reg_wr) |=> !nco_sync_kick_reg)
		else $error("Sync kick not a pulse");

	// Pin mute and readback
	mute0_on_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && dac0_pin_mute_en_reg && !tx_enable_pin_0) |=> mute0_reg)
		else $error("DAC0 not muted");
	mute1_pass_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && tx_enable_pin_1) |=> !mute1_reg)
		else $error("DAC1 muted with pin high");
	mute_readback_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && reg_rd && reg_addr == {1'b0, `SRTC_TX_MUTE_ADDR}) |=> {reg_rdata[`SRTC_MUTE1_BIT],
		reg_rdata[`SRTC_MUTE0_BIT]} == {$past(dac1_pin_mute_en_reg), $past(dac0_pin_mute_en_reg)})
		else $error("Mute enables read back wrong");
	action_readback_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clk_en && reg_rd && reg_addr == {1'b0, `SRTC_REALIGN_ADDR})
		|=> reg_rdata[1:0] == $past(action_reg))
		else $error("Action field read back wrong");
endmodule

/* File: tb/srtc_host.sv */
// Host model: drives the transmit enable pins and reference edge pulses.
// Assumes the bench supplies pin levels and edge requests on ref_clk.
`timescale 1ns/1ps
module srtc_host (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic [1:0] pin_req,
	input  wire logic       edge_req,
	output logic            tx_enable_pin_0,
	output logic            tx_enable_pin_1,
	output logic            sysref_edge
);
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			{tx_enable_pin_1, tx_enable_pin_0} <= 2'h3;
			sysref_edge <= 1'b0;
		end else begin
			{tx_enable_pin_1, tx_enable_pin_0} <= pin_req;
			sysref_edge <= edge_req;
		end
	end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the sync rotation and transmit mute control.
// Assumes srtc_ctrl and srtc_host compiled first; ramp shortened to 4 cycles.
`timescale 1ns/1ps
module testbench;
	logic       ref_clk = 1'b0;
	logic       rstn = 1'b0;
	logic       clk_en = 1'b1;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [8:0] reg_addr = 9'h0;
	logic [7:0] reg_wdata = 8'h0;
	logic [7:0] reg_rdata, gain, gmin, gat;
	logic       digital_reset = 1'b0;
	logic       edge_req = 1'b0;
	logic [1:0] pin_req = 2'h3;
	logic [1:0] e;
	logic       pin0, pin1, sref, nco_reset, link_clk_reset, rotate_pulse, dac0_mute, dac1_mute;
	int         err_count = 0;
	int         checks_done = 0;
	int         seed = 57791;
	int         n_rot, n_lnk, n_nco;
	always #25 ref_clk = ~ref_clk;
	srtc_ctrl #(.RAMP_CYCLES(4)) i_srtc_ctrl (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sysref_edge(sref), .digital_reset(digital_reset),
		.tx_enable_pin_0(pin0), .tx_enable_pin_1(pin1), .nco_reset(nco_reset),
		.link_clk_reset(link_clk_reset), .rotate_pulse(rotate_pulse), .datapath_gain(gain),
		.dac0_mute(dac0_mute), .dac1_mute(dac1_mute));
	srtc_host i_srtc_host (.ref_clk(ref_clk), .rstn(rstn), .pin_req(pin_req), .edge_req(edge_req),
		.tx_enable_pin_0(pin0), .tx_enable_pin_1(pin1), .sysref_edge(sref));
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [7:0] exp_realign(input logic nco, input logic arm, input logic done,
		input logic [1:0] act);
		return {3'h0, nco, arm, done, act};
	endfunction
	function automatic logic [1:0] exp_mute(input logic [1:0] en, input logic [1:0] pins);
		return en & ~pins;
	endfunction
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", reg_rdata, exp);
	endtask
	// Counts pulses and tracks gain over a bounded window
	task automatic win(input int n);
		n_rot = 0;
		n_lnk = 0;
		n_nco = 0;
		gmin = 8'hff;
		gat = 8'h55;
		repeat (n) begin
			#1;
			if (rotate_pulse === 1'b1) n_rot++;
			if (rotate_pulse === 1'b1) gat = gain;
			if (link_clk_reset === 1'b1) n_lnk++;
			if (nco_reset === 1'b1) n_nco++;
			if (gain < gmin) gmin = gain;
			@(posedge ref_clk);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(9'h03b, exp_realign(1'b1, 1'b0, 1'b1, 2'h0));
		rd(9'h03f, 8'h00);
		rd(9'h055, 8'h00);
		@(posedge ref_clk);
		digital_reset <= 1'b1;
		@(posedge ref_clk);
		digital_reset <= 1'b0;
		win(4);
		chk("nco_reset", 8'(n_nco), 8'h01);
		$display("reset test done");
		for (int en = 0; en < 4; en++) begin
			wr(9'h03f, {2'h0, en[1:0], 4'h0});
			rd(9'h03f, {2'h0, en[1:0], 4'h0});
			repeat (24) begin
				@(posedge ref_clk);
				e = exp_mute(en[1:0], {pin1, pin0});
				pin_req <= 2'($random(seed));
				#1;
				chk("dac1_mute", dac1_mute, e[1]);
				chk("dac0_mute", dac0_mute, e[0]);
			end
			$display("mute test %0d done", en);
		end
		// Frozen clock enable holds the mute outputs
		@(posedge ref_clk);
		pin_req <= 2'h3;
		repeat (3) @(posedge ref_clk);
		clk_en <= 1'b0;
		pin_req <= 2'h0;
		repeat (4) @(posedge ref_clk);
		#1;
		chk("dac_mute_frozen", {6'h0, dac1_mute, dac0_mute}, 8'h00);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("dac_mute_resumed", {6'h0, dac1_mute, dac0_mute}, 8'h03);
		@(posedge ref_clk);
		pin_req <= 2'h3;
		$display("clock enable test done");
		// Action bit 1 only in runs that stand for active amplifier protection
		for (int a = 0; a < 4; a++) begin
			for (int p = 0; p < 2; p++) begin
				// Second pass: no rearm, edge must be ignored
				if (p == 0) wr(9'h03b, {3'h0, a[1], 1'b1, 1'b0, a[1:0]});
				@(posedge ref_clk);
				edge_req <= 1'b1;
				@(posedge ref_clk);
				edge_req <= 1'b0;
				win(20);
			end
			chk("rotate_refused", 8'(n_rot), 8'h00);
			chk("link_refused", 8'(n_lnk), 8'h00);
			rd(9'h03b, exp_realign(a[1], 1'b0, 1'b1, a[1:0]));
			wr(9'h03b, {3'h0, a[1], 1'b1, 1'b0, a[1:0]});
			@(posedge ref_clk);
			edge_req <= 1'b1;
			@(posedge ref_clk);
			edge_req <= 1'b0;
			win(20);
			chk("rotate_pulse", 8'(n_rot), 8'h01);
			chk("link_clk_reset", 8'(n_lnk), {7'h0, a[0]});
			chk("nco_reset", 8'(n_nco), {7'h0, a[1]});
			chk("gain_at_rotate", gat, a[1] ? 8'h00 : 8'hff);
			chk("gain_min", gmin, a[1] ? 8'h00 : 8'hff);
			chk("gain_end", gain, 8'hff);
			$display("rotation test %0d done", a);
		end
		wr(9'h1e7, 8'h01);
		win(6);
		chk("nco_kick", 8'(n_nco), 8'h01);
		rd(9'h1e7, 8'h00);
		$display("nco kick test done");
		give_verdict();
	end
endmodule
